// ---- verilog/lsc_cmd_decoder.sv ----
//Behaviour
// - Peek puts one displayed byte in stack
// - Peek byte is combined text/graphic view
// - Peek outside graphic area: ignore, flag error
// - Copy writes one raster line from pointer
// - Bit command changes exactly one bit
// - Reverse bit 0 inverts whole screen
// - Blink period from bits 2..0
// - Two data bytes; Reverse uses second, Blink/Auto-move/Font use first
// - Auto-move enable from bit 0
// - Auto-move steps cursor per display transfer pulse
// - Font select 10/11 picks ROM font
module lsc_cmd_decoder (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_ce_b,
  input wire logic i_cd,
  input wire logic i_wr_b,
  input wire logic i_rd_b,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe_b,
  input wire logic [lsc_pkg::ADDR_W-1:0] i_addr_ptr,
  input wire logic [lsc_pkg::ADDR_W-1:0] i_gfx_home,
  input wire logic [lsc_pkg::ADDR_W-1:0] i_gfx_size,
  input wire logic [7:0] i_gfx_cols,
  input wire logic [1:0] i_mix_mode,
  input wire logic i_text_on,
  input wire logic i_gfx_on,
  input wire logic [7:0] i_text_pix,
  output logic o_ram_req,
  output logic o_ram_we,
  output logic [lsc_pkg::ADDR_W-1:0] o_ram_addr,
  output logic [7:0] o_ram_wdata,
  input wire logic i_ram_ack,
  input wire logic [7:0] i_ram_rdata,
  input wire logic i_disp_xfer,
  input wire logic i_cursor_dec,
  output logic o_cursor_inc,
  output logic o_cursor_dec,
  output logic o_reverse,
  output logic [2:0] o_blink_code,
  output logic o_cursor_auto,
  output logic o_font_override,
  output logic o_font_second,
  output logic o_peek_error_flag,
  output logic o_busy
);
  import lsc_pkg::*;

  typedef struct packed {
    logic ce_s1;
    logic ce_s2;
    logic cd_s1;
    logic cd_s2;
    logic wr_s1;
    logic wr_s2;
    logic wr_d;
    logic rd_s1;
    logic rd_s2;
    logic [7:0] dat_s1;
    logic [7:0] dat_s2;
    logic [7:0] first_data_byte;
    logic [7:0] second_data_byte;
    lsc_state_t state;
    lsc_op_t op;
    logic [7:0] count;
    logic bit_val;
    logic [2:0] bit_idx;
    logic [7:0] rdata;
    logic [7:0] peek_byte;
    logic peek_error_flag;
    logic reverse;
    logic [2:0] blink_code;
    logic cursor_auto;
    logic font_override;
    logic font_second;
    logic ram_req;
    logic ram_we;
    logic [ADDR_W-1:0] ram_addr;
    logic [7:0] ram_wdata;
    logic [7:0] out_data;
    logic oe_b;
    logic cursor_inc;
    logic cursor_dec;
  } lsc_core_t;

  lsc_core_t s;
  lsc_core_t next_s;

  lsc_pix_if pix ();

  lsc_pix_mix u_mix (
    .pix(pix)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Host strobe decode and graphic area check

  logic wr_done;
  logic rd_act;
  logic cmd_take;
  logic data_take;
  logic in_gfx;
  logic [ADDR_W:0] gfx_end;

  assign wr_done = s.wr_s2 & ~s.wr_d & ~s.ce_s2;
  assign rd_act = ~s.rd_s2 & ~s.ce_s2;
  // Commands arriving while busy are dropped; host polls status first
  assign cmd_take = wr_done & s.cd_s2 & (s.state == ST_IDLE);
  assign data_take = wr_done & ~s.cd_s2;
  assign gfx_end = {1'b0, i_gfx_home} + {1'b0, i_gfx_size};
  assign in_gfx = (i_addr_ptr >= i_gfx_home) && ({1'b0, i_addr_ptr} < gfx_end);

  // Graphic byte straight off the RAM return so the merge sees it with the ack
  assign pix.gfx_pix = i_ram_rdata;
  assign pix.text_pix = i_text_pix;
  assign pix.mix = i_mix_mode;
  assign pix.text_on = i_text_on;
  assign pix.gfx_on = i_gfx_on;
  assign pix.reverse = s.reverse;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [7:0] stat;
    stat = 8'h00;
    next_s = s;
    next_s.ce_s1 = i_ce_b;
    next_s.ce_s2 = s.ce_s1;
    next_s.cd_s1 = i_cd;
    next_s.cd_s2 = s.cd_s1;
    next_s.wr_s1 = i_wr_b;
    next_s.wr_s2 = s.wr_s1;
    next_s.wr_d = s.wr_s2;
    next_s.rd_s1 = i_rd_b;
    next_s.rd_s2 = s.rd_s1;
    next_s.dat_s1 = i_data;
    next_s.dat_s2 = s.dat_s1;
    next_s.cursor_inc = 1'b0;
    next_s.cursor_dec = 1'b0;

    stat[STAT_CMD_RDY] = (s.state == ST_IDLE);
    stat[STAT_DATA_RDY] = (s.state == ST_IDLE);
    stat[STAT_PEEK_ERR] = s.peek_error_flag;
    next_s.out_data = s.cd_s2 ? stat : s.peek_byte;
    next_s.oe_b = ~rd_act;

    if (data_take) begin
      next_s.first_data_byte = s.second_data_byte;
      next_s.second_data_byte = s.dat_s2;
    end

    if (cmd_take) begin
      next_s.peek_error_flag = 1'b0;
      if (s.dat_s2[7:4] == CMD_BIT_HI) begin
        next_s.op = OP_BIT;
        next_s.bit_val = s.dat_s2[BIT_SET_POS];
        next_s.bit_idx = s.dat_s2[2:0];
        next_s.ram_addr = i_addr_ptr;
        next_s.ram_req = 1'b1;
        next_s.ram_we = 1'b0;
        next_s.state = ST_READ;
      end else begin
        unique case (s.dat_s2)
          CMD_PEEK: begin
            if (in_gfx) begin
              next_s.op = OP_PEEK;
              next_s.ram_addr = i_addr_ptr;
              next_s.ram_req = 1'b1;
              next_s.ram_we = 1'b0;
              next_s.state = ST_READ;
            end else begin
              // Set after the clear above so it wins
              next_s.peek_error_flag = 1'b1;
            end
          end
          CMD_COPY: begin
            if (i_gfx_cols != 8'h00) begin
              next_s.op = OP_COPY;
              next_s.count = i_gfx_cols;
              next_s.ram_addr = i_addr_ptr;
              next_s.ram_req = 1'b1;
              next_s.ram_we = 1'b0;
              next_s.state = ST_READ;
            end
          end
          CMD_REVERSE: next_s.reverse = s.second_data_byte[REV_POS];
          CMD_BLINK: next_s.blink_code = s.first_data_byte[2:0];
          CMD_AUTOMOVE: next_s.cursor_auto = s.first_data_byte[AUTO_POS];
          CMD_FONT: begin
            next_s.font_override = s.first_data_byte[FONT_EXPLICIT_POS];
            next_s.font_second = s.first_data_byte[FONT_EXPLICIT_POS]
                                 & s.first_data_byte[FONT_WHICH_POS];
          end
          default: begin
          end
        endcase
      end
    end

    unique case (s.state)
      ST_IDLE: begin
      end
      ST_READ: begin
        if (i_ram_ack) begin
          next_s.rdata = i_ram_rdata;
          unique case (s.op)
            OP_PEEK: begin
              next_s.peek_byte = pix.shown;
              next_s.ram_req = 1'b0;
              next_s.state = ST_IDLE;
            end
            OP_COPY: begin
              next_s.ram_wdata = pix.shown;
              next_s.ram_we = 1'b1;
              next_s.state = ST_WRITE;
            end
            OP_BIT: begin
              next_s.ram_wdata = (i_ram_rdata & ~(8'h01 << s.bit_idx))
                                 | ({7'h00, s.bit_val} << s.bit_idx);
              next_s.ram_we = 1'b1;
              next_s.state = ST_WRITE;
            end
          endcase
        end
      end
      ST_WRITE: begin
        if (i_ram_ack) begin
          next_s.ram_we = 1'b0;
          if (s.op == OP_COPY && s.count > 8'h01) begin
            // Walk the raster line one byte per column
            next_s.count = s.count - 8'h01;
            next_s.ram_addr = s.ram_addr + 16'h0001;
            next_s.state = ST_READ;
          end else begin
            next_s.ram_req = 1'b0;
            next_s.state = ST_IDLE;
          end
        end
      end
    endcase

    if (i_disp_xfer && s.cursor_auto) begin
      next_s.cursor_inc = ~i_cursor_dec;
      next_s.cursor_dec = i_cursor_dec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      s <= '0;
      s.ce_s1 <= 1'b1;
      s.ce_s2 <= 1'b1;
      s.wr_s1 <= 1'b1;
      s.wr_s2 <= 1'b1;
      s.wr_d <= 1'b1;
      s.rd_s1 <= 1'b1;
      s.rd_s2 <= 1'b1;
      s.first_data_byte <= DATA_RST;
      s.second_data_byte <= DATA_RST;
      s.blink_code <= BLINK_RST;
      s.ram_addr <= ADDR_RST;
      s.state <= ST_IDLE;
      s.op <= OP_PEEK;
      s.oe_b <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign o_data = s.out_data;
  assign o_data_oe_b = s.oe_b;
  assign o_ram_req = s.ram_req;
  assign o_ram_we = s.ram_we;
  assign o_ram_addr = s.ram_addr;
  assign o_ram_wdata = s.ram_wdata;
  assign o_cursor_inc = s.cursor_inc;
  assign o_cursor_dec = s.cursor_dec;
  assign o_reverse = s.reverse;
  assign o_blink_code = s.blink_code;
  assign o_cursor_auto = s.cursor_auto;
  assign o_font_override = s.font_override;
  assign o_font_second = s.font_second;
  assign o_peek_error_flag = s.peek_error_flag;
  assign o_busy = (s.state != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);

  property p_peek_start;
    cmd_take && s.dat_s2 == CMD_PEEK && in_gfx
      |=> o_ram_req && !o_ram_we && o_ram_addr == $past(i_addr_ptr) && s.state == ST_READ;
  endproperty
  a_peek_start: assert property (p_peek_start) else $error("peek read not issued");

  property p_peek_byte;
    s.state == ST_READ && s.op == OP_PEEK && i_ram_ack
      |=> s.peek_byte == $past(pix.shown) && s.state == ST_IDLE;
  endproperty
  a_peek_byte: assert property (p_peek_byte) else $error("peek byte not merged view");

  property p_peek_err;
    cmd_take && s.dat_s2 == CMD_PEEK && !in_gfx
      |=> o_peek_error_flag && s.state == ST_IDLE && !o_ram_req;
  endproperty
  a_peek_err: assert property (p_peek_err) else $error("peek outside area not flagged");

  property p_copy_len;
    cmd_take && s.dat_s2 == CMD_COPY && i_gfx_cols == 8'h01
      |=> s.state == ST_READ ##1 (s.state != ST_IDLE) [*1] ##0 !(s.count > 8'h01);
  endproperty
  a_copy_len: assert property (p_copy_len) else $error("copy length wrong");

  property p_copy_step;
    s.state == ST_WRITE && s.op == OP_COPY && i_ram_ack && s.count > 8'h01
      |=> o_ram_addr == $past(o_ram_addr) + 16'h0001 && s.state == ST_READ;
  endproperty
  a_copy_step: assert property (p_copy_step) else $error("copy address not stepped");

  property p_bit_one;
    s.state == ST_WRITE && s.op == OP_BIT
      |-> ((o_ram_wdata ^ s.rdata) & ~(8'h01 << s.bit_idx)) == 8'h00
          && o_ram_wdata[s.bit_idx] == s.bit_val;
  endproperty
  a_bit_one: assert property (p_bit_one) else $error("bit write touched other bits");

  property p_bit_decode;
    cmd_take && s.dat_s2[7:4] == CMD_BIT_HI
      |=> s.bit_idx == $past(s.dat_s2[2:0]) && s.bit_val == $past(s.dat_s2[3]);
  endproperty
  a_bit_decode: assert property (p_bit_decode) else $error("bit command misdecoded");

  property p_reverse;
    cmd_take && s.dat_s2 == CMD_REVERSE |=> o_reverse == $past(s.second_data_byte[0]);
  endproperty
  a_reverse: assert property (p_reverse) else $error("reverse not taken");

  property p_blink;
    cmd_take && s.dat_s2 == CMD_BLINK |=> o_blink_code == $past(s.first_data_byte[2:0]);
  endproperty
  a_blink: assert property (p_blink) else $error("blink code wrong");

  property p_stack;
    data_take |=> s.first_data_byte == $past(s.second_data_byte)
                  && s.second_data_byte == $past(s.dat_s2);
  endproperty
  a_stack: assert property (p_stack) else $error("data stack shift wrong");

  property p_auto;
    cmd_take && s.dat_s2 == CMD_AUTOMOVE |=> o_cursor_auto == $past(s.first_data_byte[0]);
  endproperty
  a_auto: assert property (p_auto) else $error("auto-move enable wrong");

  property p_step;
    i_disp_xfer && o_cursor_auto |=> (o_cursor_inc ^ o_cursor_dec)
                                     && o_cursor_dec == $past(i_cursor_dec);
  endproperty
  a_step: assert property (p_step) else $error("cursor not stepped");

  property p_font;
    cmd_take && s.dat_s2 == CMD_FONT && s.first_data_byte[1:0] == 2'h3
      |=> o_font_override && o_font_second;
  endproperty
  a_font: assert property (p_font) else $error("second font not selected");
endmodule

// ---- include/lsc_pkg.sv ----
package lsc_pkg;
  // Command codes seen with the command/data select high
  localparam logic [7:0] CMD_PEEK = 8'hE0;
  localparam logic [7:0] CMD_COPY = 8'hE8;
  localparam logic [7:0] CMD_REVERSE = 8'hD0;
  localparam logic [7:0] CMD_BLINK = 8'h50;
  localparam logic [7:0] CMD_AUTOMOVE = 8'h60;
  localparam logic [7:0] CMD_FONT = 8'h70;
  localparam logic [3:0] CMD_BIT_HI = 4'hF;

  // Field positions inside the command and data bytes
  localparam int BIT_SET_POS = 3;
  localparam int REV_POS = 0;
  localparam int AUTO_POS = 0;
  localparam int FONT_EXPLICIT_POS = 1;
  localparam int FONT_WHICH_POS = 0;

  // Status byte bit positions
  localparam int STAT_CMD_RDY = 0;
  localparam int STAT_DATA_RDY = 1;
  localparam int STAT_PEEK_ERR = 6;

  // Text/graphic combination modes
  localparam logic [1:0] MIX_OR = 2'h0;
  localparam logic [1:0] MIX_XOR = 2'h1;
  localparam logic [1:0] MIX_AND = 2'h3;

  // Reset values
  localparam logic [2:0] BLINK_RST = 3'h0;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [15:0] ADDR_RST = 16'h0000;

  localparam int ADDR_W = 16;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b100
  } lsc_state_t;

  typedef enum logic [2:0] {
    OP_PEEK = 3'b001,
    OP_COPY = 3'b010,
    OP_BIT = 3'b100
  } lsc_op_t;
endpackage

// ---- include/lsc_pix_if.sv ----
interface lsc_pix_if;
  logic [7:0] text_pix;
  logic [7:0] gfx_pix;
  logic [1:0] mix;
  logic text_on;
  logic gfx_on;
  logic reverse;
  logic [7:0] shown;

  modport src(output text_pix, output gfx_pix, output mix, output text_on, output gfx_on,
              output reverse, input shown);
  modport comb(input text_pix, input gfx_pix, input mix, input text_on, input gfx_on,
               input reverse, output shown);
endinterface

// ---- verilog/lsc_pix_mix.sv ----
module lsc_pix_mix (
  lsc_pix_if.comb pix
);
  import lsc_pkg::*;

  logic [7:0] t;
  logic [7:0] g;
  logic [7:0] raw;

  always_comb begin
    t = pix.text_on ? pix.text_pix : 8'h00;
    g = pix.gfx_on ? pix.gfx_pix : 8'h00;
    unique case (pix.mix)
      MIX_OR: raw = t | g;
      MIX_XOR: raw = t ^ g;
      MIX_AND: raw = t & g;
      // Unused mode code shows as OR, the safe superset
      default: raw = t | g;
    endcase
    // Whole-screen reverse applies after the text/graphic merge
    pix.shown = raw ^ {8{pix.reverse}};
  end
endmodule

// ---- verif/lsc_host_model.sv ----
module lsc_host_model (
  input wire logic i_clk_sys,
  input wire logic [7:0] i_rdata,
  output logic o_ce_b,
  output logic o_cd,
  output logic o_wr_b,
  output logic o_rd_b,
  output logic [7:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_ce_b = 1'b1;
    o_cd = 1'b1;
    o_wr_b = 1'b1;
    o_rd_b = 1'b1;
    o_data = 8'h00;
  end
  // Operands go first, command last; pointer set by the bench first
  // Attribute and dual-scan are never used here
  task automatic wr(input logic cd, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_ce_b <= 1'b0;
    o_cd <= cd;
    o_data <= d;
    o_wr_b <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    o_wr_b <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    o_ce_b <= 1'b1;
    // Released bus must not keep the last byte
    o_data <= ~d;
    repeat (4) @(posedge i_clk_sys);
  endtask
  task automatic rd(input logic cd, output logic [7:0] v);
    @(posedge i_clk_sys);
    o_ce_b <= 1'b0;
    o_cd <= cd;
    o_rd_b <= 1'b0;
    repeat (5) @(posedge i_clk_sys);
    v = i_rdata;
    o_rd_b <= 1'b1;
    o_ce_b <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
  endtask
endmodule

// ---- verif/test_lcd_screen_command_decoder.sv ----
module test_lcd_screen_command_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, ce_b, cd, wr_b, rd_b, ton, gon, ack, xfer, cdec, slow;
  logic ram_req, ram_we, cinc, cdecp, rev, auto, fov, fsec, perr, busy, oeb;
  logic [7:0] hd, odata, tpix, ram_rd, cols, wdata;
  logic [15:0] ptr, home, gsize, raddr;
  logic [1:0] mix, dly;
  logic [2:0] blink;
  logic [7:0] mem [256];
  int bad_count, samples_checked, cyc;
  //////////////////////////////////////////////////////////////
  lsc_cmd_decoder u_lsc_cmd_decoder (.i_clk_sys(clk), .i_rst_b(rst_b), .i_ce_b(ce_b),
    .i_cd(cd), .i_wr_b(wr_b), .i_rd_b(rd_b), .i_data(hd), .o_data(odata), .o_data_oe_b(oeb),
    .i_addr_ptr(ptr), .i_gfx_home(home), .i_gfx_size(gsize), .i_gfx_cols(cols),
    .i_mix_mode(mix), .i_text_on(ton), .i_gfx_on(gon), .i_text_pix(tpix),
    .o_ram_req(ram_req), .o_ram_we(ram_we), .o_ram_addr(raddr), .o_ram_wdata(wdata),
    .i_ram_ack(ack), .i_ram_rdata(ram_rd), .i_disp_xfer(xfer), .i_cursor_dec(cdec),
    .o_cursor_inc(cinc), .o_cursor_dec(cdecp), .o_reverse(rev), .o_blink_code(blink),
    .o_cursor_auto(auto), .o_font_override(fov), .o_font_second(fsec),
    .o_peek_error_flag(perr), .o_busy(busy));
  lsc_host_model u_lsc_host_model (.i_clk_sys(clk), .i_rdata(odata), .o_ce_b(ce_b),
    .o_cd(cd), .o_wr_b(wr_b), .o_rd_b(rd_b), .o_data(hd));
  //////////////////////////////////////////////////////////////
  // Display RAM; slow mode stalls each ack by three cycles
  assign ram_rd = mem[raddr[7:0]];
  always @(posedge clk) begin
    dly <= (ram_req & ~ack) ? dly + 2'h1 : 2'h0;
    ack <= ram_req & ~ack & (!slow | dly == 2'h3);
    if (ram_req & ack & ram_we) begin
      mem[raddr[7:0]] <= wdata;
    end
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      results();
    end
  end
  //////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      bad_count++;
    end
  endtask
  task automatic idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk("busy", 8'h00, {7'h00, busy});
  endtask
  task automatic cmd3(input logic [7:0] d1, input logic [7:0] d2, input logic [7:0] c);
    u_lsc_host_model.wr(1'b0, d1);
    u_lsc_host_model.wr(1'b0, d2);
    u_lsc_host_model.wr(1'b1, c);
  endtask
  task automatic t_modes();
    for (int i = 0; i < 8; i++) begin
      cmd3(8'hF8 | 8'(i), 8'(~i), lsc_pkg::CMD_BLINK);
      chk("blink", 8'(i), {5'h00, blink});
    end
    for (int i = 3; i >= 0; i--) begin
      cmd3(8'hFC | 8'(i), 8'(~i), lsc_pkg::CMD_FONT);
      chk("font", {6'h00, i[1], i[1] & i[0]}, {6'h00, fov, fov & fsec});
    end
    for (int i = 1; i >= 0; i--) begin
      cmd3(8'hFE | 8'(i), 8'(~i), lsc_pkg::CMD_AUTOMOVE);
      chk("auto", 8'(i), {7'h00, auto});
      u_lsc_host_model.wr(1'b0, 8'hFE | 8'(i));
      u_lsc_host_model.wr(1'b1, lsc_pkg::CMD_REVERSE);
      chk("reverse", 8'(i), {7'h00, rev});
    end
    $display("test modes done");
  endtask
  task automatic pulse(input logic d, input logic [7:0] e);
    logic si, sd;
    si = 1'b0;
    sd = 1'b0;
    xfer <= 1'b1;
    cdec <= d;
    @(posedge clk);
    xfer <= 1'b0;
    // Step pulse stands one cycle right after the sampling edge
    repeat (3) begin
      #1;
      si |= cinc;
      sd |= cdecp;
      @(posedge clk);
    end
    chk("cursor step", e, {6'h00, sd, si});
  endtask
  task automatic t_cursor();
    cmd3(8'h01, 8'h00, lsc_pkg::CMD_AUTOMOVE);
    pulse(1'b0, 8'h01);
    pulse(1'b1, 8'h02);
    cmd3(8'h00, 8'hFF, lsc_pkg::CMD_AUTOMOVE);
    pulse(1'b0, 8'h00);
    $display("test cursor done");
  endtask
  task automatic t_bit();
    logic [7:0] c [4] = '{8'hFB, 8'hF0, 8'hF7, 8'hFE};
    logic [7:0] e [4] = '{8'hAD, 8'hAC, 8'h2C, 8'h6C};
    slow <= 1'b1;
    mem[8'h10] = 8'hA5;
    mem[8'h11] = 8'h5A;
    ptr <= 16'h0010;
    for (int i = 0; i < 4; i++) begin
      u_lsc_host_model.wr(1'b1, c[i]);
      idle();
      chk("bit", e[i], mem[8'h10]);
    end
    chk("neighbour", 8'h5A, mem[8'h11]);
    slow <= 1'b0;
    $display("test bit done");
  endtask
  task automatic t_peek();
    logic [7:0] v;
    // Strap and software column counts taken as equal here
    home <= 16'h0040;
    gsize <= 16'h0020;
    ptr <= 16'h0045;
    mem[8'h45] = 8'h0F;
    tpix <= 8'h3C;
    mix <= lsc_pkg::MIX_XOR;
    u_lsc_host_model.wr(1'b1, lsc_pkg::CMD_PEEK);
    idle();
    u_lsc_host_model.rd(1'b0, v);
    chk("peek byte", 8'h33, v);
    u_lsc_host_model.rd(1'b1, v);
    chk("status", 8'h03, v);
    // First address past the area end
    ptr <= 16'h0060;
    u_lsc_host_model.wr(1'b1, lsc_pkg::CMD_PEEK);
    chk("peek error", 8'h01, {7'h00, perr});
    u_lsc_host_model.rd(1'b1, v);
    chk("status err", 8'h43, v);
    u_lsc_host_model.rd(1'b0, v);
    chk("stack kept", 8'h33, v);
    u_lsc_host_model.wr(1'b1, lsc_pkg::CMD_BLINK);
    chk("error cleared", 8'h00, {7'h00, perr});
    $display("test peek done");
  endtask
  task automatic t_copy();
    for (int i = 0; i < 4; i++) begin
      mem[8'h20 + 8'(i)] = 8'h01 + 8'(i);
    end
    cols <= 8'h03;
    ptr <= 16'h0020;
    tpix <= 8'h10;
    mix <= lsc_pkg::MIX_OR;
    u_lsc_host_model.wr(1'b1, lsc_pkg::CMD_COPY);
    idle();
    for (int i = 0; i < 4; i++) begin
      chk("copy", (i < 3) ? 8'h11 + 8'(i) : 8'h04, mem[8'h20 + 8'(i)]);
    end
    $display("test copy done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    ptr = 16'h0000;
    home = 16'h0000;
    gsize = 16'h0100;
    cols = 8'h01;
    mix = 2'h0;
    ton = 1'b1;
    gon = 1'b1;
    tpix = 8'h00;
    ack = 1'b0;
    dly = 2'h0;
    slow = 1'b0;
    xfer = 1'b0;
    cdec = 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    chk("reset", 8'h00, {blink, rev, auto, fov, fsec, perr});
    chk("oe idle", 8'h01, {7'h00, oeb});
    t_modes();
    t_cursor();
    t_bit();
    t_peek();
    t_copy();
    results();
  end
endmodule
